/* File: pw_mem_map.svh */
`ifndef PW_MEM_MAP_SVH
`define PW_MEM_MAP_SVH
// reference clock and nonvolatile cycle timing
`define REF_CLK_NS 8
`define NV_WRITE_NS 5000000
`define NV_WRITE_CYC (`NV_WRITE_NS / `REF_CLK_NS)
// array organisation
`define SECTOR_COUNT 4'he
`define STORE_BYTES 128
`define LAST_DATA 7'h6f
`define WPW_BASE 7'h70
`define RPW_BASE 7'h78
// command codes
`define CMD_POLL 8'h55
`define CMD_CHG_WPW 8'hfc
`define CMD_CHG_RPW 8'hfe
`define CMD_SECT_TOP 3'h4
// reset answer, value arbitrary
`define ANSWER_DEF 32'h5a3c_0081
// write staging buffer
`define FIFO_DEPTH 32
`endif

/* File: pw_mem_pkg.sv */
`default_nettype none
package pw_mem_pkg;
  // protocol phases
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_PWD, ST_WDATA, ST_RDATA, ST_WAIT, ST_RANS}
    proto_st_t;
  // pending operation of the session
  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_CHG_W, OP_CHG_R} op_t;
endpackage : pw_mem_pkg
`default_nettype wire

/* File: mem_port_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface mem_port_if;
  logic wen;
  logic [6:0] waddr;
  logic [7:0] wdata;
  logic [6:0] raddr;
  logic [7:0] rdata;
  modport ctl (output wen, waddr, wdata, raddr, input rdata);
  modport store (input wen, waddr, wdata, raddr, output rdata);
endinterface : mem_port_if
`default_nettype wire

/* File: byte_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pw_mem_map.svh"
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FIFO_DEPTH
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ff, rd_ff;
  logic full, empty;
  // extra pointer bit tells full from empty
  assign empty = (wr_ff == rd_ff);
  assign full = (wr_ff[AW] != rd_ff[AW]) && (wr_ff[AW-1:0] == rd_ff[AW-1:0]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_ff[rd_ff[AW-1:0]];
  // pointers
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || flush_i)
    begin
      wr_ff <= '0;
      rd_ff <= '0;
    end
    else
    begin
      if (in_valid_i && !full)
        wr_ff <= wr_ff + (AW+1)'(1);
      if (out_ready_i && !empty)
        rd_ff <= rd_ff + (AW+1)'(1);
    end
  end
  // storage
  always_ff @(posedge ref_clk_i)
  begin
    if (in_valid_i && !full)
      mem_ff[wr_ff[AW-1:0]] <= in_data_i;
  end
endmodule : byte_fifo
`default_nettype wire

/* File: sector_store.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pw_mem_map.svh"
module sector_store #(
  parameter int BYTES = `STORE_BYTES
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  mem_port_if.store mp
);
  logic [7:0] cell_ff [BYTES];
  logic [7:0] rdata_ff;
  assign mp.rdata = rdata_ff;
  // array and both passwords, all zero after reset
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < BYTES; i++)
        cell_ff[i] <= 8'h00;
    end
    else if (mp.wen)
      cell_ff[mp.waddr] <= mp.wdata;
  end
  // registered read port
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      rdata_ff <= 8'h00;
    else
      rdata_ff <= cell_ff[mp.raddr];
  end
endmodule : sector_store
`default_nettype wire

/* File: sector_protocol.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pw_mem_map.svh"
// Functional notes
// RULE1: host sends write command with sector, then password, then data
// RULE2: write lands at sector start; exactly eight data bytes required
// RULE3: stop after last acked data byte launches the nonvolatile cycle
// RULE4: any byte count other than eight leaves the sector untouched
// RULE5: commands get no-ack while the cycle runs, ack afterwards
// RULE6: each password entry is always followed by a nonvolatile cycle
// RULE7: host continues after password by polling with code 55h
// RULE8: host may wait 10 ms and poll once, or poll in a loop
// RULE9: matching password acks the poll once the cycle is over
// RULE10: wrong password never acks the poll
// RULE11: read uses read code with sector; data only after password ack
// RULE12: host acks every read byte to keep the read going
// RULE13: reads start at sector first byte; no random addressing
// RULE14: reading runs on through sectors and wraps after the last one
// RULE15: host ends a read with no ack then a stop
// RULE16: password change is a sector write authorised by write password
// RULE17: polling after a password change acks once it is stored
// RULE18: no path reads either password back
// RULE19: reset pulse with select low starts a 32-bit answer stream
// RULE20: reset pulse during a nonvolatile cycle gives no answer
// RULE21: reset mid-transaction halts, data floats; select high aborts answer
// RULE22: clocks past 32 bits repeat the answer from byte 0
// RULE23: fourteen sectors of eight bytes, accesses sector aligned
// RULE24: codes fch and feh change write and read passwords
// RULE25: unknown command byte gets no-ack and device goes to standby
// RULE26: standby after each transaction and after failed access
// RULE27: sector index beyond the last sector is treated as illegal
module sector_protocol
  import pw_mem_pkg::*;
#(
  parameter int NV_CYC = `NV_WRITE_CYC,
  parameter logic [31:0] ANSWER = `ANSWER_DEF
)
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic cs_n_i,
  input wire logic reset_pin_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic nv_busy_o
);
  localparam int NVW = $clog2(NV_CYC + 1);

  mem_port_if mp ();
  logic [3:0] meta_ff, sync_ff, prev_ff;
  logic scl_rise, scl_fall, scl_hi, sda_lvl, cs_hi, rpin_lvl, rpin_rise;
  logic start_ev, stop_ev, ack_go, ack_end, rx_state;
  logic is_poll, is_chg, is_sect, cmd_ack, pw_last, commit_go, rst_hit;
  proto_st_t st_ff, nxt_st;
  op_t op_ff;
  logic [3:0] bit_cnt_ff, sect_ff, wr_cnt_ff;
  logic [7:0] rx_ff, tx_ff;
  logic oe_ff, host_ack_ff;
  logic [2:0] pw_idx_ff, cm_cnt_ff;
  logic pw_match_ff, pw_pend_ff, pw_ok_ff, wr_ovf_ff, commit_ff;
  logic [6:0] rd_ptr_ff, cm_base_ff;
  logic [NVW-1:0] nv_cnt_ff;
  logic [4:0] ans_idx_ff;
  logic fifo_flush, fifo_in_ready, fifo_out_valid;
  logic [7:0] fifo_out_data;

  sector_store u_store (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .mp(mp)
  );

  // stages up to 32 received bytes; a stop after exactly eight commits them
  byte_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .flush_i(fifo_flush),
    .in_valid_i(ack_go && st_ff == ST_WDATA),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rx_ff),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(commit_ff),
    .out_data_o(fifo_out_data)
  );

  // two-stage synchronisers, then one history stage for edges
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      meta_ff <= 4'h7;
      sync_ff <= 4'h7;
      prev_ff <= 4'h7;
    end
    else
    begin
      meta_ff <= {reset_pin_i, cs_n_i, sda_i, scl_i};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // pin events
  assign scl_hi = sync_ff[0];
  assign sda_lvl = sync_ff[1];
  assign cs_hi = sync_ff[2];
  assign rpin_lvl = sync_ff[3];
  assign scl_rise = sync_ff[0] && !prev_ff[0];
  assign scl_fall = !sync_ff[0] && prev_ff[0];
  assign rpin_rise = sync_ff[3] && !prev_ff[3];
  assign start_ev = scl_hi && prev_ff[0] && prev_ff[1] && !sda_lvl && !cs_hi && !oe_ff;
  assign stop_ev = scl_hi && prev_ff[0] && !prev_ff[1] && sda_lvl && !cs_hi && !oe_ff;

  // byte framing points: ack clock begins, ack clock ends
  assign ack_go = scl_fall && bit_cnt_ff == 4'd8;
  assign ack_end = scl_fall && bit_cnt_ff == 4'd9;
  assign rx_state = (st_ff == ST_CMD) || (st_ff == ST_PWD) || (st_ff == ST_WDATA)
                 || (st_ff == ST_RDATA);

  // command decode
  assign is_poll = (rx_ff == `CMD_POLL);
  assign is_chg = (rx_ff == `CMD_CHG_WPW) || (rx_ff == `CMD_CHG_RPW); // RULE24
  assign is_sect = (rx_ff[7:5] == `CMD_SECT_TOP) && (rx_ff[4:1] < `SECTOR_COUNT); // RULE27
  // busy nacks everything; a pending password acks only if it matched
  assign cmd_ack = !nv_busy_o
                && (is_poll ? (!pw_pend_ff || pw_ok_ff) : (is_sect || is_chg)); // RULE5 RULE9

  assign pw_last = (st_ff == ST_PWD) && ack_end && pw_idx_ff == 3'd7;
  assign commit_go = stop_ev && st_ff == ST_WDATA && wr_cnt_ff == 4'd8 && !wr_ovf_ff; // RULE3
  assign rst_hit = rpin_rise && !cs_hi && !nv_busy_o; // RULE20
  assign nv_busy_o = (nv_cnt_ff != '0);
  assign fifo_flush = !commit_ff
                   && (start_ev || cs_hi || rst_hit || (stop_ev && !commit_go)); // RULE4

  // next protocol phase
  always_comb
  begin
    nxt_st = st_ff;
    if (cs_hi)
      nxt_st = ST_IDLE; // RULE21
    else if (rst_hit)
      nxt_st = (st_ff == ST_IDLE) ? ST_RANS : ST_WAIT; // RULE19 RULE21
    else if (st_ff != ST_RANS && start_ev)
      nxt_st = ST_CMD;
    else if (st_ff != ST_RANS && stop_ev)
      nxt_st = ST_IDLE; // RULE26
    else if (ack_end)
    begin
      unique case (st_ff)
        ST_CMD:
          if (!oe_ff)
            nxt_st = ST_WAIT; // RULE25
          else if (!is_poll)
            nxt_st = ST_PWD; // RULE1
          else if (!pw_pend_ff)
            nxt_st = ST_WAIT;
          else
            nxt_st = (op_ff == OP_READ) ? ST_RDATA : ST_WDATA; // RULE11 RULE7
        ST_PWD:
          if (pw_idx_ff == 3'd7)
            nxt_st = ST_WAIT;
        ST_RDATA:
          if (!host_ack_ff)
            nxt_st = ST_WAIT; // RULE15
        ST_IDLE, ST_WDATA, ST_WAIT, ST_RANS:
          nxt_st = st_ff;
      endcase
    end
  end

  // phase register
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      st_ff <= ST_IDLE;
    else
      st_ff <= nxt_st;
  end

  // bit counting and receive shifting on clock rises
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      bit_cnt_ff <= 4'h0;
      rx_ff <= 8'h00;
      host_ack_ff <= 1'b0;
    end
    else
    begin
      if (start_ev || ack_end || !rx_state)
        bit_cnt_ff <= 4'h0;
      else if (scl_rise)
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      if (rx_state && scl_rise && bit_cnt_ff < 4'd8)
        rx_ff <= {rx_ff[6:0], sda_lvl};
      if (st_ff == ST_RDATA && scl_rise && bit_cnt_ff == 4'd8)
        host_ack_ff <= !sda_lvl; // RULE12
    end
  end

  // open-drain data drive: acks, read bits and the reset answer
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      oe_ff <= 1'b0;
      tx_ff <= 8'h00;
    end
    else if (cs_hi || rst_hit || start_ev || stop_ev)
      oe_ff <= 1'b0; // RULE21
    else if (st_ff == ST_RANS)
      oe_ff <= !rpin_lvl && !ANSWER[ans_idx_ff]; // RULE19
    else if (ack_go)
    begin
      unique case (st_ff)
        ST_CMD: oe_ff <= cmd_ack;
        ST_PWD: oe_ff <= 1'b1;
        ST_WDATA: oe_ff <= fifo_in_ready;
        ST_RDATA: oe_ff <= 1'b0;
        ST_IDLE, ST_WAIT, ST_RANS: oe_ff <= 1'b0;
      endcase
    end
    else if (ack_end && nxt_st == ST_RDATA)
    begin
      tx_ff <= mp.rdata;
      oe_ff <= !mp.rdata[7];
    end
    else if (ack_end)
      oe_ff <= 1'b0;
    else if (st_ff == ST_RDATA && scl_fall && bit_cnt_ff != 4'd0)
    begin
      tx_ff <= {tx_ff[6:0], 1'b0};
      oe_ff <= !tx_ff[6];
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_ff;

  // session: operation, sector, password check and read pointer
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || stop_ev || cs_hi)
    begin
      op_ff <= OP_WRITE;
      sect_ff <= 4'h0;
      pw_idx_ff <= 3'h0;
      pw_match_ff <= 1'b0;
      pw_pend_ff <= 1'b0;
      pw_ok_ff <= 1'b0;
      rd_ptr_ff <= 7'h00;
    end
    else
    begin
      if (ack_go && st_ff == ST_CMD && cmd_ack && !is_poll)
      begin
        op_ff <= is_sect ? (rx_ff[0] ? OP_READ : OP_WRITE)
               : (rx_ff == `CMD_CHG_WPW ? OP_CHG_W : OP_CHG_R);
        sect_ff <= rx_ff[4:1];
        rd_ptr_ff <= {rx_ff[4:1], 3'h0}; // RULE13 RULE23
        pw_idx_ff <= 3'h0;
        pw_match_ff <= 1'b1;
        pw_pend_ff <= 1'b0;
        pw_ok_ff <= 1'b0;
      end
      if (ack_go && st_ff == ST_PWD)
        pw_match_ff <= pw_match_ff && (rx_ff == mp.rdata);
      if (ack_end && st_ff == ST_PWD)
        pw_idx_ff <= pw_idx_ff + 3'h1;
      if (pw_last)
      begin
        pw_pend_ff <= 1'b1;
        pw_ok_ff <= pw_match_ff; // RULE10
      end
      // pointer stays inside the data area
      if (st_ff == ST_RDATA && scl_rise && bit_cnt_ff == 4'd8 && !sda_lvl)
        rd_ptr_ff <= (rd_ptr_ff == `LAST_DATA) ? 7'h00 : rd_ptr_ff + 7'h01; // RULE14 RULE18
    end
  end

  // read port: stored password while it is checked, data otherwise
  assign mp.raddr = (st_ff == ST_PWD)
                  ? ((op_ff == OP_READ ? `RPW_BASE : `WPW_BASE) | {4'h0, pw_idx_ff}) // RULE16
                  : rd_ptr_ff;

  // incoming data byte count
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || (ack_end && st_ff == ST_CMD))
    begin
      wr_cnt_ff <= 4'h0;
      wr_ovf_ff <= 1'b0;
    end
    else if (ack_go && st_ff == ST_WDATA)
    begin
      if (wr_cnt_ff != 4'hf)
        wr_cnt_ff <= wr_cnt_ff + 4'h1;
      if (!fifo_in_ready)
        wr_ovf_ff <= 1'b1;
    end
  end

  // commit of staged bytes from the sector's first location
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
    begin
      commit_ff <= 1'b0;
      cm_cnt_ff <= 3'h0;
      cm_base_ff <= 7'h00;
    end
    else if (commit_go)
    begin
      commit_ff <= 1'b1;
      cm_cnt_ff <= 3'h0;
      unique case (op_ff)
        OP_CHG_W: cm_base_ff <= `WPW_BASE;
        OP_CHG_R: cm_base_ff <= `RPW_BASE;
        OP_WRITE, OP_READ: cm_base_ff <= {sect_ff, 3'h0}; // RULE2
      endcase
    end
    else if (commit_ff && fifo_out_valid)
    begin
      cm_cnt_ff <= cm_cnt_ff + 3'h1;
      if (cm_cnt_ff == 3'd7)
        commit_ff <= 1'b0;
    end
  end

  assign mp.wen = commit_ff && fifo_out_valid;
  assign mp.waddr = {cm_base_ff[6:3], cm_cnt_ff};
  assign mp.wdata = fifo_out_data;

  // nonvolatile cycle timer
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i)
      nv_cnt_ff <= '0;
    else if (commit_go || pw_last)
      nv_cnt_ff <= NVW'(NV_CYC); // RULE6 RULE3
    else if (nv_busy_o)
      nv_cnt_ff <= nv_cnt_ff - NVW'(1); // RULE17
  end

  // reset answer bit index, advanced by each clock fall while the reset pin is low
  always_ff @(posedge ref_clk_i)
  begin
    if (rst_i || st_ff != ST_RANS)
      ans_idx_ff <= 5'h00;
    else if (scl_fall && !rpin_lvl)
      ans_idx_ff <= ans_idx_ff + 5'h01; // RULE22
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence commit_run;
    commit_ff [*8] ##1 !commit_ff;
  endsequence

  busy_cmd_nack_a: assert property ( // RULE5
    ack_go && st_ff == ST_CMD && nv_busy_o |=> !oe_ff)
    else $error("command acked during write cycle");
  bad_pw_poll_a: assert property ( // RULE10
    ack_go && st_ff == ST_CMD && is_poll && pw_pend_ff && !pw_ok_ff |=> !oe_ff)
    else $error("poll acked after wrong password");
  short_write_a: assert property ( // RULE4
    stop_ev && st_ff == ST_WDATA && wr_cnt_ff != 4'd8 |=> !commit_ff [*3])
    else $error("short write committed");
  commit_len_a: assert property ( // RULE2
    $rose(commit_ff) |-> commit_run)
    else $error("commit not eight bytes");
  pw_nv_a: assert property ( // RULE6
    pw_last |=> nv_busy_o && nv_cnt_ff == NVW'(NV_CYC))
    else $error("password entry without write cycle");
  rd_wrap_a: assert property ( // RULE14
    st_ff == ST_RDATA && scl_rise && bit_cnt_ff == 4'd8 && !sda_lvl
    && rd_ptr_ff == `LAST_DATA && !cs_hi && !stop_ev |=> rd_ptr_ff == 7'h00)
    else $error("read pointer did not wrap");
  ans_wrap_a: assert property ( // RULE22
    st_ff == ST_RANS && scl_fall && !rpin_lvl && ans_idx_ff == 5'd31 && !cs_hi
    |=> ans_idx_ff == 5'd0)
    else $error("answer did not restart");
  ans_abort_a: assert property ( // RULE21
    st_ff == ST_RANS && cs_hi |=> st_ff == ST_IDLE && !oe_ff)
    else $error("answer not aborted by deselect");
  illegal_cmd_a: assert property ( // RULE25
    ack_go && st_ff == ST_CMD && !is_poll && !is_sect && !is_chg
    |=> !oe_ff ##[1:1000] (st_ff == ST_WAIT || st_ff == ST_IDLE))
    else $error("illegal command acked");
  rans_busy_a: assert property ( // RULE20
    rpin_rise && nv_busy_o && st_ff != ST_RANS |=> st_ff != ST_RANS)
    else $error("answer during write cycle");
endmodule : sector_protocol
`default_nettype wire

/* File: host_master.sv */
`timescale 1ns/1ps
`default_nettype none
// host side of the two-wire link, paced by the reference clock
module host_master
(
  input wire logic ref_clk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_oe_o,
  output logic cs_n_o,
  output logic reset_pin_o,
  output logic seen_o,
  output logic [7:0] seen_val_o
);
  logic quiet;
  // idle pins: link clock stands high, data released
  initial
  begin
    scl_o = 1'b1;
    sda_oe_o = 1'b0;
    cs_n_o = 1'b1;
    reset_pin_o = 1'b0;
    seen_o = 1'b0;
    seen_val_o = 8'h00;
    quiet = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : tick
  // hand a received value to the watcher
  task automatic report(input logic [7:0] v);
    seen_val_o = v;
    seen_o = 1'b1;
    #1 seen_o = 1'b0;
  endtask : report
  task automatic select(input logic on);
    cs_n_o = ~on;
    tick(8);
  endtask : select
  task automatic pulse_reset;
    reset_pin_o = 1'b1;
    tick(5);
    reset_pin_o = 1'b0;
    tick(8);
  endtask : pulse_reset
  // data moves mid-low, sampled late in the high phase
  task automatic clk_bit(input logic pull, output logic smp);
    tick(2);
    sda_oe_o = pull;
    tick(3);
    scl_o = 1'b1;
    tick(4);
    smp = sda_i;
    tick(1);
    scl_o = 1'b0;
  endtask : clk_bit
  // start, also a repeated start after an ack clock
  task automatic start;
    tick(2);
    sda_oe_o = 1'b0;
    tick(3);
    scl_o = 1'b1;
    tick(5);
    sda_oe_o = 1'b1;
    tick(5);
    scl_o = 1'b0;
  endtask : start
  task automatic stop;
    tick(2);
    sda_oe_o = 1'b1;
    tick(3);
    scl_o = 1'b1;
    tick(5);
    sda_oe_o = 1'b0;
    tick(5);
  endtask : stop
  // eight bits msb first, then the ack clock
  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(~b[i], s);
    clk_bit(1'b0, s);
    ack = ~s;
    if (!quiet)
      report({7'h00, ack});
  endtask : send_byte
  task automatic recv_byte(input logic ack_it, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b0, v[i]);
    clk_bit(ack_it, s);
    report(v);
  endtask : recv_byte
  task automatic answer_bits(input int n);
    for (int i = 0; i < n; i++)
    begin
      report({7'h00, sda_i});
      scl_o = 1'b0;
      tick(5);
      scl_o = 1'b1;
      tick(5);
    end
  endtask : answer_bits
endmodule : host_master
`default_nettype wire

/* File: password_sector_memory_protocol_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pw_mem_map.svh"
module password_sector_memory_protocol_test;
  // reset answer pattern, value arbitrary; bit 0 low so a stray answer pulls the line
  localparam logic [31:0] ANS = 32'hc3a5_1e68;
  logic ref_clk, rst, sda, dev_oe, dev_sda, nv_busy, scl, host_oe, cs_n, reset_pin, seen;
  logic [7:0] seen_val;
  logic [7:0] mem [0:111];
  logic [7:0] exp_q [$];
  logic [63:0] wpw, rpw, dat;
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  // open-drain data line with pull-up
  assign sda = (dev_oe ? dev_sda : 1'b1) & ~host_oe;
  sector_protocol #(.NV_CYC(200), .ANSWER(ANS)) i_sector_protocol (.ref_clk_i(ref_clk),
    .rst_i(rst), .scl_i(scl), .sda_i(sda), .cs_n_i(cs_n), .reset_pin_i(reset_pin),
    .sda_o(dev_sda), .sda_oe_o(dev_oe), .nv_busy_o(nv_busy));
  host_master i_host_master (.ref_clk_i(ref_clk), .sda_i(sda), .scl_o(scl), .sda_oe_o(host_oe),
    .cs_n_o(cs_n), .reset_pin_o(reset_pin), .seen_o(seen), .seen_val_o(seen_val));
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic check(input logic [7:0] got, input logic [7:0] want, input string what);
    checks_done++;
    if (got !== want)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, want, got);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // oldest expectation against each result seen
  always @(posedge seen)
  begin
    if (exp_q.size() == 0)
      check(8'h01, 8'h00, "unexpected result");
    else
      check(seen_val, exp_q.pop_front(), "link result");
  end
  // cycle ceiling cuts a hang short
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      close_out();
    end
  end
  // repeated polls until acked, bounded
  task automatic poll(output logic first, output logic a);
    i_host_master.quiet = 1'b1;
    a = 1'b0;
    for (int t = 0; t < 10 && !a; t++)
    begin
      i_host_master.start();
      i_host_master.send_byte(`CMD_POLL, a);
      if (t == 0)
        first = a;
    end
    i_host_master.quiet = 1'b0;
  endtask : poll
  task automatic session(input logic [7:0] cmd, input logic [63:0] pw, input logic ok);
    logic a, f;
    exp_q.push_back(8'h01);
    i_host_master.start();
    i_host_master.send_byte(cmd, a);
    for (int i = 0; i < 8; i++)
    begin
      exp_q.push_back(8'h01);
      i_host_master.send_byte(pw[63 - 8 * i -: 8], a);
    end
    poll(f, a);
    check(f, 1'b0, "first password poll");
    check(a, ok, "password poll");
  endtask : session
  task automatic write_sec(input logic [7:0] cmd, input logic [63:0] pw, input logic [63:0] d,
    input int n);
    logic a, f;
    session(cmd, pw, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back(8'h01);
      i_host_master.send_byte(d[63 - 8 * i -: 8], a);
    end
    i_host_master.stop();
    if (n == 8)
    begin
      i_host_master.tick(10);
      check(nv_busy, 1'b1, "busy after stop");
      i_host_master.pulse_reset();
      check(dev_oe, 1'b0, "no answer while busy");
    end
    poll(f, a);
    check(a, 1'b1, "write poll");
    if (n == 8)
      check(f, 1'b0, "poll while busy");
    if (n == 8 && cmd[7:5] == 3'b100)
      for (int i = 0; i < 8; i++)
        mem[cmd[4:1] * 8 + i] = d[63 - 8 * i -: 8];
    if (n == 8 && cmd == `CMD_CHG_WPW)
      wpw = d;
    if (n == 8 && cmd == `CMD_CHG_RPW)
      rpw = d;
  endtask : write_sec
  task automatic read_sec(input int sec, input logic [63:0] pw, input int n);
    logic [7:0] v;
    session({3'b100, sec[3:0], 1'b1}, pw, 1'b1);
    for (int i = 0; i < n; i++)
    begin
      exp_q.push_back(mem[(sec * 8 + i) % 112]);
      i_host_master.recv_byte(i < n - 1, v);
    end
    i_host_master.stop();
  endtask : read_sec
  initial
  begin
    logic a;
    logic [7:0] bad [4];
    rst = 1'b1;
    wpw = '0;
    rpw = '0;
    for (int i = 0; i < 112; i++)
      mem[i] = 8'h00;
    void'($urandom(15097));
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'b0;
    i_host_master.tick(4);
    // answer stream runs past 32 bits, then deselect aborts it
    i_host_master.select(1'b1);
    i_host_master.pulse_reset();
    for (int i = 0; i < 40; i++)
      exp_q.push_back({7'h00, ANS[i % 32]});
    i_host_master.answer_bits(40);
    i_host_master.select(1'b0);
    check(dev_oe, 1'b0, "released on deselect");
    i_host_master.select(1'b1);
    // illegal codes and missing sectors are refused
    bad = '{{2'b00, 6'($urandom)}, 8'h9c, 8'h9f, 8'hfd};
    foreach (bad[k])
    begin
      exp_q.push_back(8'h00);
      i_host_master.start();
      i_host_master.send_byte(bad[k], a);
      i_host_master.stop();
    end
    // reset pulse mid-transaction halts it until the next stop
    exp_q.push_back(8'h01);
    exp_q.push_back(8'h00);
    i_host_master.start();
    i_host_master.send_byte(8'h80, a);
    i_host_master.pulse_reset();
    i_host_master.send_byte(8'h00, a);
    i_host_master.stop();
    // sector writes, both password changes, short write
    dat = {$urandom, $urandom};
    write_sec(8'h9a, wpw, dat, 8);
    write_sec(`CMD_CHG_WPW, wpw, {$urandom, $urandom}, 8);
    write_sec(`CMD_CHG_RPW, wpw, {$urandom, $urandom}, 8);
    write_sec(8'h80, wpw, {$urandom, $urandom}, 8);
    write_sec(8'h80, wpw, {$urandom, $urandom}, 7);
    read_sec(13, rpw, 16);
    // wrong read password then standby
    session(8'h81, ~rpw, 1'b0);
    i_host_master.stop();
    read_sec(0, rpw, 3);
    check(exp_q.size() == 0, 1'b1, "all results seen");
    close_out();
  end
endmodule : password_sector_memory_protocol_test
`default_nettype wire
